// ===== rtl/rsp_pkg.sv
package rsp_pkg;
  // ==========================================================
  // Widths and encodings
  localparam int PC_WIDTH = 21;
  localparam int INSTR_WIDTH = 16;
  localparam int STACK_DEPTH = 31;
  localparam int PTR_WIDTH = 5;
  localparam logic [15:0] OPC_IDLE_ZERO = 16'h0000;
  localparam logic [15:0] OPC_PUSH = 16'h0005;
  localparam logic [15:0] OPC_POP = 16'h0006;
  localparam logic [3:0] OPC_IDLE_TOP_NIBBLE = 4'hF;
  localparam logic [20:0] PC_STEP = 21'h00_0002;
  localparam logic [20:0] ENTRY_RESET = 21'h00_0000;
  localparam logic [4:0] PTR_RESET = 5'h00;

  typedef enum logic [1:0] {
    RSP_OP_IDLE = 2'b00,
    RSP_OP_PUSH = 2'b01,
    RSP_OP_POP = 2'b10,
    RSP_OP_OTHER = 2'b11
  } rsp_op_e;

  // Instruction issued to the block
  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic [20:0] pc;
  } rsp_issue_s;

  // Software write of the stack top entry
  typedef struct packed {
    logic write;
    logic [20:0] value;
  } rsp_top_write_s;
endpackage : rsp_pkg

// ===== rtl/rsp_decode.sv
`timescale 1ns/10ps
module rsp_decode
  import rsp_pkg::*;
(
  // Instruction word
  input wire logic [15:0] word_in,
  // Decoded class
  output rsp_pkg::rsp_op_e op_out
);
  always_comb begin
    if (word_in == OPC_PUSH) begin
      op_out = RSP_OP_PUSH; // RULE_03
    end else if (word_in == OPC_POP) begin
      op_out = RSP_OP_POP; // RULE_01
    end else if (word_in == OPC_IDLE_ZERO || word_in[15:12] == OPC_IDLE_TOP_NIBBLE) begin
      op_out = RSP_OP_IDLE; // RULE_06
    end else begin
      op_out = RSP_OP_OTHER;
    end
  end
endmodule : rsp_decode

// ===== rtl/rsp_return_stack.sv
`timescale 1ns/10ps
// What this block does
// [RULE_01] Pop (word 0006) removes the top return-stack entry and discards it.
// [RULE_02] After pop the previously pushed entry is top; PC untouched.
// [RULE_03] Push (word 0005) stores program counter plus 2 on top.
// [RULE_04] Push moves the former top one level deeper, preserved.
// [RULE_05] Software may write the top entry; a later push buries it.
// [RULE_06] Zero word or top nibble F is a one-cycle idle; no state changes.
module rsp_return_stack
  import rsp_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Instruction issue
  input rsp_pkg::rsp_issue_s issue_in,
  // Software access to the top entry
  input rsp_pkg::rsp_top_write_s top_write_in,
  // Stack state
  output logic [20:0] stack_top_entry_out,
  output logic [4:0] depth_out,
  output logic overflow_out,
  output logic underflow_out,
  output logic done_out
);
  import rsp_pkg::*;

  // ==========================================================
  // Decode
  rsp_op_e op;
  logic do_push;
  logic do_pop;

  rsp_decode u_decode (
    .word_in(issue_in.word),
    .op_out(op)
  );

  assign do_push = issue_in.valid && (op == RSP_OP_PUSH);
  assign do_pop = issue_in.valid && (op == RSP_OP_POP);

  // ==========================================================
  // Storage: slot 0 unused, pointer names the top slot
  logic [20:0] entry [1:DEPTH];
  logic [4:0] ptr;
  logic [4:0] next_ptr;
  logic [20:0] push_value;

  assign push_value = issue_in.pc + PC_STEP; // RULE_03

  always_comb begin
    next_ptr = ptr;
    if (do_push && ptr != 5'(DEPTH)) begin
      next_ptr = ptr + 5'h01; // RULE_04
    end else if (do_pop && ptr != PTR_RESET) begin
      next_ptr = ptr - 5'h01; // RULE_02
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ptr <= PTR_RESET;
    end else begin
      ptr <= next_ptr; // RULE_01
    end
  end

  // Older entries stay in place, so the deeper level is preserved on push
  genvar g;
  generate
    for (g = 1; g <= DEPTH; g++) begin : g_slot
      always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          entry[g] <= ENTRY_RESET;
        end else if (do_push && next_ptr == 5'(g) && ptr != 5'(DEPTH)) begin
          entry[g] <= push_value; // RULE_03
        end else if (!do_push && !do_pop && top_write_in.write && ptr == 5'(g)) begin
          entry[g] <= top_write_in.value; // RULE_05
        end
      end
    end
  endgenerate

  // ==========================================================
  // Outputs
  // Full stack drops the push instead of overwriting the deepest entry
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      overflow_out <= 1'b0;
    end else begin
      overflow_out <= do_push && ptr == 5'(DEPTH); // RULE_04
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      underflow_out <= 1'b0;
    end else begin
      underflow_out <= do_pop && ptr == PTR_RESET; // RULE_01
    end
  end

  // Unknown words give no done, so the core can flag them elsewhere
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= issue_in.valid && (op != RSP_OP_OTHER); // RULE_06
    end
  end

  assign stack_top_entry_out = (ptr == PTR_RESET) ? ENTRY_RESET : entry[ptr];
  assign depth_out = ptr;

  // ==========================================================
  // Checks
  a_push_top_value: assert property ( // RULE_03
    @(posedge clock_in) disable iff (!reset_n_in)
    do_push && ptr != 5'(DEPTH) |=> stack_top_entry_out == $past(push_value)
  ) else $error("push did not store pc plus two");

  a_push_buries_top: assert property ( // RULE_04
    @(posedge clock_in) disable iff (!reset_n_in)
    do_push && ptr != 5'(DEPTH) ##1 do_pop && !$past(top_write_in.write)
    |=> stack_top_entry_out == $past(stack_top_entry_out, 2)
  ) else $error("former top lost by push");

  a_pop_depth: assert property ( // RULE_01
    @(posedge clock_in) disable iff (!reset_n_in)
    do_pop && ptr != PTR_RESET |=> depth_out == $past(depth_out) - 5'h01
  ) else $error("pop did not remove top");

  a_pop_restores: assert property ( // RULE_02
    @(posedge clock_in) disable iff (!reset_n_in)
    do_push && ptr != 5'(DEPTH) && !top_write_in.write ##1 do_pop
    |=> stack_top_entry_out == $past(stack_top_entry_out, 2)
  ) else $error("pop did not restore previous top");

  a_top_write: assert property ( // RULE_05
    @(posedge clock_in) disable iff (!reset_n_in)
    top_write_in.write && !do_push && !do_pop && ptr != PTR_RESET
    |=> stack_top_entry_out == $past(top_write_in.value)
  ) else $error("top entry write lost");

  a_idle_stable: assert property ( // RULE_06
    @(posedge clock_in) disable iff (!reset_n_in)
    issue_in.valid && op == RSP_OP_IDLE && !top_write_in.write
    |=> $stable(depth_out) && $stable(stack_top_entry_out)
  ) else $error("idle instruction changed the stack");

  a_done_one_cycle: assert property ( // RULE_06
    @(posedge clock_in) disable iff (!reset_n_in)
    issue_in.valid && op != RSP_OP_OTHER |=> done_out
  ) else $error("instruction not finished in one cycle");

  a_push_depth: assert property ( // RULE_04
    @(posedge clock_in) disable iff (!reset_n_in)
    do_push && ptr != 5'(DEPTH) |=> depth_out == $past(depth_out) + 5'h01
  ) else $error("push did not deepen stack");

  a_full_push_ignored: assert property ( // RULE_04
    @(posedge clock_in) disable iff (!reset_n_in)
    do_push && ptr == 5'(DEPTH)
    |=> overflow_out && $stable(depth_out) && $stable(stack_top_entry_out)
  ) else $error("push on full stack changed it");

  a_empty_pop_ignored: assert property ( // RULE_01
    @(posedge clock_in) disable iff (!reset_n_in)
    do_pop && ptr == PTR_RESET |=> underflow_out && depth_out == PTR_RESET
  ) else $error("pop on empty stack misbehaved");

  a_other_no_done: assert property ( // RULE_06
    @(posedge clock_in) disable iff (!reset_n_in)
    issue_in.valid && op == RSP_OP_OTHER |=> !done_out
  ) else $error("unknown word reported done");

  a_done_needs_issue: assert property ( // RULE_06
    @(posedge clock_in) disable iff (!reset_n_in)
    !issue_in.valid |=> !done_out
  ) else $error("done without an instruction");

  a_empty_write_ignored: assert property ( // RULE_05
    @(posedge clock_in) disable iff (!reset_n_in)
    top_write_in.write && ptr == PTR_RESET && !do_push
    |=> stack_top_entry_out == ENTRY_RESET
  ) else $error("write landed on empty stack");

  a_depth_bound: assert property ( // RULE_04
    @(posedge clock_in) disable iff (!reset_n_in)
    depth_out <= 5'(DEPTH)
  ) else $error("depth beyond stack size");

  a_pop_no_flag: assert property ( // RULE_06
    @(posedge clock_in) disable iff (!reset_n_in)
    do_pop && ptr != PTR_RESET |=> !underflow_out && !overflow_out
  ) else $error("legal pop raised a flag");

  a_push_no_flag: assert property ( // RULE_06
    @(posedge clock_in) disable iff (!reset_n_in)
    do_push && ptr != 5'(DEPTH) |=> !overflow_out && !underflow_out
  ) else $error("legal push raised a flag");

  a_pop_new_top: assert property ( // RULE_02
    @(posedge clock_in) disable iff (!reset_n_in)
    do_pop && ptr > 5'h01 |=> stack_top_entry_out == $past(entry[ptr - 5'h01])
  ) else $error("pop exposed the wrong entry");

  c_push_pop: cover property (
    @(posedge clock_in) disable iff (!reset_n_in)
    do_push ##1 do_pop);

  c_write_push: cover property (
    @(posedge clock_in) disable iff (!reset_n_in)
    top_write_in.write ##1 do_push);

  c_overflow: cover property (
    @(posedge clock_in) disable iff (!reset_n_in)
    overflow_out);

  c_underflow: cover property (
    @(posedge clock_in) disable iff (!reset_n_in)
    underflow_out);

  c_idle: cover property (
    @(posedge clock_in) disable iff (!reset_n_in)
    issue_in.valid && op == RSP_OP_IDLE);
endmodule : rsp_return_stack

// ===== test/tb.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb;
  import rsp_pkg::*;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  rsp_issue_s issue = '0;
  rsp_top_write_s top_write = '0;
  logic [20:0] top;
  logic [4:0] depth;
  logic overflow, underflow, done;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;

  always #4 clock_in = ~clock_in;

  rsp_return_stack i_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .issue_in(issue),
    .top_write_in(top_write), .stack_top_entry_out(top), .depth_out(depth),
    .overflow_out(overflow), .underflow_out(underflow), .done_out(done));

  // ==========================================================
  // Drivers and comparison
  task automatic op(input logic [15:0] word, input logic [20:0] pc);
    @(posedge clock_in);
    issue <= '{valid: 1'b1, word: word, pc: pc};
    @(posedge clock_in);
    issue.valid <= 1'b0;
    #1;
  endtask : op

  task automatic expect_state(input logic [20:0] e_top, input logic [4:0] e_depth);
    `CHK("top", e_top, top)
    `CHK("depth", e_depth, depth)
    `CHK("done", 1'b1, done)
    `CHK("underflow", 1'b0, underflow)
    `CHK("overflow", 1'b0, overflow)
  endtask : expect_state

  // ==========================================================
  // Scenarios
  task automatic push_deep;
    op(OPC_PUSH, 21'h00_0124);
    expect_state(21'h00_0126, 5'h01);
    op(OPC_PUSH, 21'h00_0200);
    expect_state(21'h00_0202, 5'h02);
    op(OPC_POP, 21'h00_0202);
    expect_state(21'h00_0126, 5'h01);
  endtask : push_deep

  task automatic soft_top;
    @(posedge clock_in);
    top_write <= '{write: 1'b1, value: 21'h00_345A};
    @(posedge clock_in);
    top_write.write <= 1'b0;
    #1;
    `CHK("written top", 21'h00_345A, top)
    op(OPC_PUSH, 21'h00_0300);
    expect_state(21'h00_0302, 5'h02);
    op(OPC_POP, 21'h00_0302);
    expect_state(21'h00_345A, 5'h01);
  endtask : soft_top

  task automatic idle_words;
    logic [15:0] words [3] = '{16'h0000, 16'hF000, 16'hFFFF};
    foreach (words[i]) begin
      op(words[i], 21'h00_0400);
      expect_state(21'h00_345A, 5'h01);
    end
  endtask : idle_words

  task automatic pop_discard;
    op(OPC_POP, 21'h00_0500);
    expect_state(21'h00_0000, 5'h00);
    // Empty stack refuses the pop rather than wrapping
    op(OPC_POP, 21'h00_0502);
    `CHK("underflow", 1'b1, underflow)
    `CHK("empty depth", 5'h00, depth)
    @(posedge clock_in);
    top_write <= '{write: 1'b1, value: 21'h00_0ABC};
    @(posedge clock_in);
    top_write.write <= 1'b0;
    #1;
    `CHK("empty write", 21'h00_0000, top)
  endtask : pop_discard

  task automatic fill_overflow;
    logic [20:0] pc;
    pc = 21'h00_1000;
    for (int i = 1; i <= STACK_DEPTH; i++) begin
      op(OPC_PUSH, pc);
      `CHK("fill depth", 5'(i), depth)
      pc = pc + 21'h00_0004;
    end
    op(OPC_PUSH, pc);
    `CHK("overflow", 1'b1, overflow)
    `CHK("full depth", 5'(STACK_DEPTH), depth)
    `CHK("full top", pc - 21'h00_0002, top)
  endtask : fill_overflow

  task automatic race_other;
    @(posedge clock_in);
    issue <= '{valid: 1'b1, word: OPC_POP, pc: 21'h00_0600};
    top_write <= '{write: 1'b1, value: 21'h00_7777};
    @(posedge clock_in);
    issue.valid <= 1'b0;
    top_write.write <= 1'b0;
    #1;
    `CHK("pop beats write", 21'h00_1076, top)
    `CHK("pop depth", 5'(STACK_DEPTH - 1), depth)
    op(16'h0007, 21'h00_0700);
    `CHK("other done", 1'b0, done)
    `CHK("other depth", 5'(STACK_DEPTH - 1), depth)
  endtask : race_other

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // ==========================================================
  // Hang guard, far above the hundred or so cycles needed
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    repeat (12) @(posedge clock_in);
    reset_n_in <= 1'b1;
    push_deep();
    soft_top();
    idle_words();
    pop_discard();
    fill_overflow();
    race_other();
    final_report();
  end
endmodule : tb
